//--- gcs_pkg.sv
// Constants and types for the common command and status block
package gcs_pkg;
   localparam logic [7:0] ADDR_CMD  = 8'h00;
   localparam logic [7:0] ADDR_RESP = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;
   localparam logic [7:0] ADDR_CTRL = 8'h0C;
   localparam logic [7:0] ADDR_EVT  = 8'h10;
   localparam int CMD_OP_LSB     = 0;
   localparam int CMD_ARG_LSB    = 8;
   localparam int RESP_VALID_BIT = 31;
   localparam int STAT_TALK_BIT  = 16;
   localparam int STAT_LISN_BIT  = 17;
   localparam int STAT_REM_BIT   = 18;
   localparam int STAT_SRQ_BIT   = 19;
   localparam int STAT_OPC_BIT   = 20;
   localparam int STB_MSS_BIT    = 6;
   localparam int STB_ESB_BIT    = 5;
   localparam int STB_MAV_BIT    = 4;
   localparam int ESR_OPC_BIT    = 0;
   localparam int ESR_CME_BIT    = 5;
   localparam int CTRL_TRIG_BIT  = 0;
   localparam int CTRL_OUT_BIT   = 1;
   localparam int CTRL_INST_LSB  = 8;
   localparam logic [7:0]  SRE_MASK  = 8'hBF;
   localparam logic [7:0]  INST_MASK = 8'h8F;
   localparam logic [7:0]  REG8_RST  = 8'h00;
   localparam logic [15:0] CTRL_RST  = 16'h0000;
   localparam int BM_MLA   = 0;
   localparam int BM_MTA   = 1;
   localparam int BM_UNL   = 2;
   localparam int BM_UNT   = 3;
   localparam int BM_GTL   = 4;
   localparam int BM_GET   = 5;
   localparam int BM_DCL   = 6;
   localparam int BM_REN   = 7;
   localparam int BM_PPOLL = 8;
   localparam int BM_N     = 9;
   typedef enum logic [3:0] {
      OP_CLS   = 4'h0,
      OP_ESE   = 4'h1,
      OP_ESE_Q = 4'h2,
      OP_ESR_Q = 4'h3,
      OP_IDN_Q = 4'h4,
      OP_IST_Q = 4'h5,
      OP_OPC   = 4'h6,
      OP_OPC_Q = 4'h7,
      OP_PRE   = 4'h8,
      OP_PRE_Q = 4'h9,
      OP_SRE   = 4'hA,
      OP_SRE_Q = 4'hB,
      OP_STB_Q = 4'hC,
      OP_TRG   = 4'hD,
      OP_RST   = 4'hE
   } gcs_op_type;
endpackage

//--- gcs_top.sv
// Common command interpreter and status structure with APB registers
//
// Operation
// - Bus behaviour follows the decoded 488.1 interface messages and 488.2 status conventions.
// - Service request, clear and trigger functions; no source or acceptor handshake.
// - Talker with serial poll; talker state drops on own listen address.
// - Listener; listener state drops on own talk address.
// - Remote and local switching, no local lockout state.
// - Parallel poll answered; response enable set remotely.
// - Common commands start with an asterisk; some are queries only.
// - Clear-status command clears event status and response flag, not instrument bits; no parameter.
// - Event enable command loads 8 bits; query returns them.
// - Event status query returns the 8-bit event register.
// - Identification query returns maker, model and revision.
// - Individual status is poll enable ANDed with status byte.
// - Operation-complete sets its event flag when nothing is pending.
// - Operation-complete query answers one once work is done.
// - Poll enable command writes 8 low bits; query returns them.
// - Poll source register equals the status byte query value.
// - Service enable accepts only values with bit 6 clear.
// - Status byte query carries master summary in bit 6.
// - Trigger pulses only when the bus is the trigger source.
// - Reset restores default settings and turns output off.
// - Event summary bit set by any enabled event bit.
// - Serial poll reads the status byte without changing it.
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/10ps
module gcs_top #(
   parameter logic [7:0] ID_MAKER = 8'h11,
   parameter logic [7:0] ID_MODEL = 8'h22,
   parameter logic [7:0] ID_REV   = 8'h01
) (
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   input  wire logic        i_busy,
   input  wire logic        i_bus_mla,
   input  wire logic        i_bus_mta,
   input  wire logic        i_bus_unl,
   input  wire logic        i_bus_unt,
   input  wire logic        i_bus_gtl,
   input  wire logic        i_bus_get,
   input  wire logic        i_bus_dcl,
   input  wire logic        i_bus_ren,
   input  wire logic        i_bus_ppoll,
   output logic             o_srq,
   output logic             o_pp_resp,
   output logic      [7:0]  o_spoll_byte,
   output logic             o_trig,
   output logic             o_output_on,
   output logic             o_talker,
   output logic             o_listener,
   output logic             o_remote
);
   import gcs_pkg::*;
   // ID values above are arbitrary

   function automatic logic addr_ok(input logic [7:0] a);
      if (a == ADDR_CMD) addr_ok = 1'b1;
      else if (a == ADDR_RESP) addr_ok = 1'b1;
      else if (a == ADDR_STAT) addr_ok = 1'b1;
      else if (a == ADDR_CTRL) addr_ok = 1'b1;
      else if (a == ADDR_EVT) addr_ok = 1'b1;
      else addr_ok = 1'b0;
   endfunction

   logic [BM_N-1:0] bm_in;
   logic [BM_N-1:0] sync1_q;
   logic [BM_N-1:0] sync2_q;
   logic [BM_N-1:0] prev_q;
   logic [BM_N-1:0] rise;
   logic            acc;
   logic            wr_fire;
   logic            rd_fire;
   logic            cmd_fire;
   gcs_op_type      op;
   logic [7:0]      arg;
   logic [7:0]      ese_q;
   logic [7:0]      sre_q;
   logic [7:0]      pre_q;
   logic [7:0]      esr_q;
   logic [7:0]      esr_d;
   logic [15:0]     ctrl_q;
   logic [23:0]     resp_q;
   logic            resp_valid_q;
   logic            opc_pend_q;
   logic            opcq_pend_q;
   logic [7:0]      stb_raw;
   logic [7:0]      stb_mss;
   logic            esb;
   logic            mss;
   logic            ist;
   logic [31:0]     rd_mux;

   assign bm_in = {i_bus_ppoll, i_bus_ren, i_bus_dcl, i_bus_get, i_bus_gtl,
                   i_bus_unt, i_bus_unl, i_bus_mta, i_bus_mla};

   // Two-flop synchronisers, edge detect on second stage
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
         prev_q  <= '0;
      end
      else
      begin
         sync1_q <= bm_in;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end
   assign rise = sync2_q & ~prev_q;

   // APB slave, one wait state
   assign acc      = i_psel & i_penable;
   assign wr_fire  = acc & o_pready & i_pwrite;
   assign rd_fire  = acc & o_pready & ~i_pwrite;
   assign cmd_fire = wr_fire & (i_paddr == ADDR_CMD);
   assign op       = gcs_op_type'(i_pwdata[CMD_OP_LSB +: 4]);
   assign arg      = i_pwdata[CMD_ARG_LSB +: 8];

   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= '0;
      end
      else
      begin
         o_pready  <= acc & ~o_pready;
         o_pslverr <= acc & ~o_pready & ~addr_ok(i_paddr);
         if (acc & ~o_pready & ~i_pwrite)
            o_prdata <= rd_mux;
      end
   end

   // Status byte, summary and individual status
   assign esb = |(esr_q & ese_q);
   assign stb_raw = (ctrl_q[CTRL_INST_LSB +: 8] & INST_MASK)
                  | ({7'h00, esb} << STB_ESB_BIT)
                  | ({7'h00, resp_valid_q} << STB_MAV_BIT);
   assign mss = |(stb_raw & sre_q & SRE_MASK);
   assign stb_mss = stb_raw | ({7'h00, mss} << STB_MSS_BIT);
   assign ist = |(pre_q & stb_mss);

   always_comb
   begin
      rd_mux = '0;
      if (i_paddr == ADDR_RESP)
      begin
         rd_mux[23:0]           = resp_q;
         rd_mux[RESP_VALID_BIT] = resp_valid_q;
      end
      else if (i_paddr == ADDR_STAT)
      begin
         rd_mux[7:0]           = stb_mss;
         rd_mux[15:8]          = esr_q;
         rd_mux[STAT_TALK_BIT] = o_talker;
         rd_mux[STAT_LISN_BIT] = o_listener;
         rd_mux[STAT_REM_BIT]  = o_remote;
         rd_mux[STAT_SRQ_BIT]  = o_srq;
         rd_mux[STAT_OPC_BIT]  = opc_pend_q | opcq_pend_q;
      end
      else if (i_paddr == ADDR_CTRL)
         rd_mux[15:0] = ctrl_q;
   end

   // Enable registers
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         ese_q <= REG8_RST;
         sre_q <= REG8_RST;
         pre_q <= REG8_RST;
      end
      else if (cmd_fire)
      begin
         if (op == OP_ESE)
            ese_q <= arg;
         if (op == OP_PRE)
            pre_q <= arg;
         if (op == OP_SRE && !arg[STB_MSS_BIT])
            sre_q <= arg;
      end
   end

   // Control: trigger source, output, instrument status bits
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
         ctrl_q <= CTRL_RST;
      else if (cmd_fire && op == OP_RST)
         ctrl_q <= CTRL_RST;
      else if (wr_fire && i_paddr == ADDR_CTRL)
         ctrl_q <= i_pwdata[15:0];
   end
   assign o_output_on = ctrl_q[CTRL_OUT_BIT];

   // Standard event status: clears first, sets win
   always_comb
   begin
      esr_d = esr_q;
      if (cmd_fire && (op == OP_CLS || op == OP_ESR_Q))
         esr_d = '0;
      if (wr_fire && i_paddr == ADDR_EVT)
         esr_d = esr_d | i_pwdata[7:0];
      if (opc_pend_q && !i_busy)
         esr_d[ESR_OPC_BIT] = 1'b1;
      if (cmd_fire && op == OP_SRE && arg[STB_MSS_BIT])
         esr_d[ESR_CME_BIT] = 1'b1;
   end
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
         esr_q <= REG8_RST;
      else
         esr_q <= esr_d;
   end

   // Pending operation-complete requests
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         opc_pend_q  <= 1'b0;
         opcq_pend_q <= 1'b0;
      end
      else if (rise[BM_DCL] || (cmd_fire && op inside {OP_CLS, OP_RST}))
      begin
         opc_pend_q  <= 1'b0;
         opcq_pend_q <= 1'b0;
      end
      else
      begin
         if (cmd_fire && op == OP_OPC)
            opc_pend_q <= 1'b1;
         else if (!i_busy)
            opc_pend_q <= 1'b0;
         if (cmd_fire && op == OP_OPC_Q)
            opcq_pend_q <= 1'b1;
         else if (!i_busy)
            opcq_pend_q <= 1'b0;
      end
   end

   // Query response; new answer wins over a read clear
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         resp_q       <= '0;
         resp_valid_q <= 1'b0;
      end
      else if (opcq_pend_q && !i_busy && !rise[BM_DCL] &&
               !(cmd_fire && op == OP_CLS))
      begin
         resp_q       <= 24'h000001;
         resp_valid_q <= 1'b1;
      end
      else if (cmd_fire && op inside {OP_ESE_Q, OP_ESR_Q, OP_IDN_Q,
                                      OP_IST_Q, OP_PRE_Q, OP_SRE_Q,
                                      OP_STB_Q})
      begin
         resp_valid_q <= 1'b1;
         case (op)
            OP_ESE_Q: resp_q <= {16'h0000, ese_q};
            OP_ESR_Q: resp_q <= {16'h0000, esr_q};
            OP_IDN_Q: resp_q <= {ID_MAKER, ID_MODEL, ID_REV};
            OP_IST_Q: resp_q <= {23'h000000, ist};
            OP_PRE_Q: resp_q <= {16'h0000, pre_q};
            OP_SRE_Q: resp_q <= {16'h0000, sre_q};
            default:  resp_q <= {16'h0000, stb_mss};
         endcase
      end
      else if (rise[BM_DCL] || (cmd_fire && op == OP_CLS) ||
               (rd_fire && i_paddr == ADDR_RESP))
         resp_valid_q <= 1'b0;
   end

   // Talker, listener and remote states
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_talker   <= 1'b0;
         o_listener <= 1'b0;
         o_remote   <= 1'b0;
      end
      else
      begin
         if (rise[BM_MLA] || rise[BM_UNT])
            o_talker <= 1'b0;
         else if (rise[BM_MTA])
            o_talker <= 1'b1;
         if (rise[BM_MTA] || rise[BM_UNL])
            o_listener <= 1'b0;
         else if (rise[BM_MLA])
            o_listener <= 1'b1;
         if (!sync2_q[BM_REN] || rise[BM_GTL])
            o_remote <= 1'b0;
         else if (rise[BM_MLA])
            o_remote <= 1'b1;
      end
   end

   // Poll answers, service request and trigger pulse
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_srq        <= 1'b0;
         o_pp_resp    <= 1'b0;
         o_spoll_byte <= '0;
         o_trig       <= 1'b0;
      end
      else
      begin
         o_srq        <= mss;
         o_pp_resp    <= sync2_q[BM_PPOLL] & ist;
         o_spoll_byte <= stb_mss;
         o_trig       <= ctrl_q[CTRL_TRIG_BIT] &
                         ((cmd_fire && op == OP_TRG) ||
                          (rise[BM_GET] && o_listener));
      end
   end

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   sequence s_cmd(gcs_op_type c);
      cmd_fire && op == c;
   endsequence

   a_sre_bit_six: assert property (!sre_q[STB_MSS_BIT])
      else $error("service enable bit 6 set");
   a_cls_clears: assert property (s_cmd(OP_CLS) |=> !resp_valid_q)
      else $error("clear status left response");
   a_ese_load: assert property (s_cmd(OP_ESE) |=> ese_q == $past(arg))
      else $error("event enable not loaded");
   a_esr_query: assert property (s_cmd(OP_ESR_Q) ##1 1 |->
      resp_q[7:0] == $past(esr_q, 1) && resp_valid_q)
      else $error("event status query wrong");
   a_opc_flag: assert property (opc_pend_q && !i_busy |=>
      esr_q[ESR_OPC_BIT])
      else $error("operation complete flag missing");
   a_opc_hold: assert property (opc_pend_q && i_busy && !cmd_fire &&
      !rise[BM_DCL] |=> opc_pend_q)
      else $error("operation complete ended early");
   a_trig_gate: assert property (o_trig |-> $past(ctrl_q[CTRL_TRIG_BIT]))
      else $error("trigger without bus source");
   a_rst_output: assert property (s_cmd(OP_RST) |=> !o_output_on)
      else $error("reset left output on");
   a_talk_drop: assert property (rise[BM_MLA] |=> !o_talker)
      else $error("talker kept on listen address");
   a_listen_drop: assert property (rise[BM_MTA] |=> !o_listener)
      else $error("listener kept on talk address");
   a_esb_summary: assert property (##1 o_spoll_byte[STB_ESB_BIT] ==
      $past(|(esr_q & ese_q)))
      else $error("event summary bit wrong");
endmodule // gcs_top

//--- gcs_ctl_model.sv
// Bus controller model driving the decoded interface messages
`timescale 1ns/10ps
module gcs_ctl_model
   import gcs_pkg::*;
(
   input  wire logic i_clk_sys,
   output logic      o_bus_mla,
   output logic      o_bus_mta,
   output logic      o_bus_unl,
   output logic      o_bus_unt,
   output logic      o_bus_gtl,
   output logic      o_bus_get,
   output logic      o_bus_dcl,
   output logic      o_bus_ren,
   output logic      o_bus_ppoll
);
   logic [BM_N-1:0] msg_q = '0;

   assign o_bus_mla   = msg_q[BM_MLA];
   assign o_bus_mta   = msg_q[BM_MTA];
   assign o_bus_unl   = msg_q[BM_UNL];
   assign o_bus_unt   = msg_q[BM_UNT];
   assign o_bus_gtl   = msg_q[BM_GTL];
   assign o_bus_get   = msg_q[BM_GET];
   assign o_bus_dcl   = msg_q[BM_DCL];
   assign o_bus_ren   = msg_q[BM_REN];
   assign o_bus_ppoll = msg_q[BM_PPOLL];

   // Each message level is held five clocks, past the synchroniser
   task automatic msg(input int idx, input logic lvl);
      @(posedge i_clk_sys);
      msg_q[idx] <= lvl;
      repeat (5) @(posedge i_clk_sys);
   endtask
endmodule // gcs_ctl_model

//--- tb_gcs_top.sv
// Self-checking bench for the common command and status block
`timescale 1ns/10ps
module tb_gcs_top;
   import gcs_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic        busy = 1'b0;
   logic [31:0] prdata, rd;
   logic [7:0]  spoll;
   logic        pready, pslverr, srq, pp_resp, trig, out_on, err;
   logic        talker, listener, remote;
   logic        mla, mta, unl, unt, gtl, get, dcl, ren, ppoll;
   int          errors = 0;
   int          checks_done = 0;
   int          cycles = 0;
   int          trigs = 0;

   always #2 clk = ~clk;

   gcs_top i_gcs_top (
      .i_clk_sys(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_busy(busy), .i_bus_mla(mla), .i_bus_mta(mta), .i_bus_unl(unl),
      .i_bus_unt(unt), .i_bus_gtl(gtl), .i_bus_get(get), .i_bus_dcl(dcl),
      .i_bus_ren(ren), .i_bus_ppoll(ppoll), .o_srq(srq),
      .o_pp_resp(pp_resp), .o_spoll_byte(spoll), .o_trig(trig),
      .o_output_on(out_on), .o_talker(talker), .o_listener(listener),
      .o_remote(remote)
   );

   gcs_ctl_model i_gcs_ctl_model (
      .i_clk_sys(clk), .o_bus_mla(mla), .o_bus_mta(mta), .o_bus_unl(unl),
      .o_bus_unt(unt), .o_bus_gtl(gtl), .o_bus_get(get), .o_bus_dcl(dcl),
      .o_bus_ren(ren), .o_bus_ppoll(ppoll)
   );

   task automatic results();
      if (errors == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (trig === 1'b1)
         trigs++;
      if (cycles == 5000)
      begin
         errors++;
         results();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Common command: opcode plus argument byte
   task automatic cmd(input gcs_op_type op, input logic [7:0] arg);
      apb(1'b1, ADDR_CMD, {16'h0000, arg, 4'h0, op});
   endtask

   task automatic qry(input gcs_op_type op, input logic [23:0] exp);
      cmd(op, 8'h00);
      apb(1'b0, ADDR_RESP, 32'h0);
      chk(rd, {8'h80, exp});
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rdchk(ADDR_STAT, 32'h0);
      apb(1'b0, 8'h14, 32'h0);
      chk({31'h0, err}, 32'h1);
      cmd(OP_SRE, 8'h60);
      qry(OP_ESR_Q, 24'h20);
      qry(OP_SRE_Q, 24'h00);
      cmd(OP_ESE, 8'h24);
      qry(OP_ESE_Q, 24'h24);
      apb(1'b1, ADDR_EVT, 32'h21);
      rdchk(ADDR_STAT, 32'h0000_2120);
      cmd(OP_SRE, 8'h20);
      rdchk(ADDR_STAT, 32'h0008_2160);
      chk({24'h0, spoll}, 32'h60);
      chk({31'h0, srq}, 32'h1);
      rdchk(ADDR_STAT, 32'h0008_2160);
      cmd(OP_PRE, 8'h20);
      qry(OP_PRE_Q, 24'h20);
      qry(OP_IST_Q, 24'h1);
      qry(OP_STB_Q, 24'h60);
      i_gcs_ctl_model.msg(BM_PPOLL, 1'b1);
      chk({31'h0, pp_resp}, 32'h1);
      i_gcs_ctl_model.msg(BM_PPOLL, 1'b0);
      chk({31'h0, pp_resp}, 32'h0);
      qry(OP_ESR_Q, 24'h21);
      rdchk(ADDR_STAT, 32'h0);
      chk({31'h0, srq}, 32'h0);
      apb(1'b1, ADDR_EVT, 32'h01);
      cmd(OP_CLS, 8'h00);
      rdchk(ADDR_STAT, 32'h0);
      qry(OP_IDN_Q, 24'h112201);
      busy <= 1'b1;
      cmd(OP_OPC, 8'h00);
      rdchk(ADDR_STAT, 32'h0010_0000);
      busy <= 1'b0;
      repeat (2) @(posedge clk);
      rdchk(ADDR_STAT, 32'h0000_0100);
      qry(OP_OPC_Q, 24'h1);
      qry(OP_ESR_Q, 24'h1);
      cmd(OP_TRG, 8'h00);
      apb(1'b1, ADDR_CTRL, 32'h1);
      cmd(OP_TRG, 8'h00);
      repeat (2) @(posedge clk);
      chk(trigs, 32'h1);
      apb(1'b1, ADDR_CTRL, 32'h2);
      repeat (2) @(posedge clk);
      chk({31'h0, out_on}, 32'h1);
      cmd(OP_RST, 8'h00);
      rdchk(ADDR_CTRL, 32'h0);
      chk({31'h0, out_on}, 32'h0);
      i_gcs_ctl_model.msg(BM_REN, 1'b1);
      i_gcs_ctl_model.msg(BM_MLA, 1'b1);
      i_gcs_ctl_model.msg(BM_MLA, 1'b0);
      chk({29'h0, listener, talker, remote}, 32'h5);
      i_gcs_ctl_model.msg(BM_MTA, 1'b1);
      i_gcs_ctl_model.msg(BM_MTA, 1'b0);
      chk({29'h0, listener, talker, remote}, 32'h3);
      i_gcs_ctl_model.msg(BM_GTL, 1'b1);
      i_gcs_ctl_model.msg(BM_GTL, 1'b0);
      chk({29'h0, listener, talker, remote}, 32'h2);
      apb(1'b1, ADDR_CTRL, 32'h1);
      i_gcs_ctl_model.msg(BM_MLA, 1'b1);
      i_gcs_ctl_model.msg(BM_MLA, 1'b0);
      chk({29'h0, listener, talker, remote}, 32'h5);
      i_gcs_ctl_model.msg(BM_GET, 1'b1);
      i_gcs_ctl_model.msg(BM_GET, 1'b0);
      chk(trigs, 32'h2);
      i_gcs_ctl_model.msg(BM_UNL, 1'b1);
      i_gcs_ctl_model.msg(BM_UNL, 1'b0);
      chk({29'h0, listener, talker, remote}, 32'h1);
      busy <= 1'b1;
      cmd(OP_OPC, 8'h00);
      i_gcs_ctl_model.msg(BM_DCL, 1'b1);
      i_gcs_ctl_model.msg(BM_DCL, 1'b0);
      busy <= 1'b0;
      repeat (2) @(posedge clk);
      rdchk(ADDR_STAT, 32'h0004_0000);
      results();
   end
endmodule // tb_gcs_top
